// [logic/instrument_status_reporting.sv]
`timescale 1ns/10ps
// Notes on behaviour
// (R1) ten slots: save and recall instrument state
// (R2) trigger starts only when source is bus
// (R3) command syntax selectable: scpi or native
// (R4) masked status byte ORed sets bit 6
// (R5) status byte query returns current byte
// (R6) request mask set and queried back
// (R7) bit 0: local pressed during remote
// (R8) status bits 1 and 7 read zero
// (R9) bit 2 set on command-language error
// (R10) bit 3 summarises questionable conditions
// (R11) bit 4 while a message is waiting
// (R12) masked events ORed set bit 5
// (R13) event mask set/queried, events queried
// (R14) event bit 0 on pending operations done
// (R15) event bit 2 on query error
// (R16) event bit 4 on execution error
// (R17) event bit 5 on invalid command
// (R18) event bit 7 after power cycle
// (R19) event bits 1, 3, 6 read zero
// (R20) questionable bit 10 when output unleveled
// (R21) questionable bit 11 when synthesizer unlocked
// (R22) questionable bit 12 on lost reference
// (R23) event query clears event flags
module instrument_status_reporting (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rstn,
	// command port
	input wire logic i_cmd_valid,
	input wire status_reporting_pkg::cmd_code_t i_cmd_code,
	input wire logic [7:0] i_cmd_arg,
	input wire logic [status_reporting_pkg::STATE_W-1:0] i_current_state,
	// event and condition sources
	input wire logic i_remote_mode,
	input wire logic i_local_press,
	input wire logic i_lang_error,
	input wire logic i_message_waiting,
	input wire logic i_ops_done,
	input wire logic i_query_error,
	input wire logic i_exec_error,
	input wire logic i_command_error,
	input wire logic i_power_cycled,
	input wire logic i_output_level_loop_unleveled,
	input wire logic i_synth_unlocked,
	input wire logic i_ext_ref_lost,
	// responses
	output logic o_resp_valid,
	output logic [15:0] o_resp_data,
	// state recall
	output logic o_recall_valid,
	output logic [status_reporting_pkg::STATE_W-1:0] o_recall_state,
	// control outputs
	output logic o_trigger_start,
	output logic o_syntax_scpi,
	output logic o_service_request
);
	import status_reporting_pkg::*;

	logic [STATE_W-1:0] slot_q [SLOT_COUNT];
	logic [7:0] srq_mask_q;
	logic [7:0] event_mask_q;
	logic [7:0] event_flags_q;
	logic [7:0] event_flags_d;
	logic unleveled_q;
	logic unlocked_q;
	logic no_ref_q;
	logic [15:0] questionable_condition_flags_word;
	logic [7:0] status_q;
	logic [7:0] status_d;
	logic local_q;
	logic error_q;
	logic trig_bus_q;
	logic slot_ok;
	logic [3:0] slot_idx;
	// decoded command strobes
	logic save_hit;
	logic recall_hit;
	logic trigger_hit;
	logic scpi_hit;
	logic native_hit;
	logic srq_mask_set_hit;
	logic srq_mask_query_hit;
	logic status_query_hit;
	logic event_mask_set_hit;
	logic event_mask_query_hit;
	logic event_query_hit;
	logic questionable_condition_flags_query_hit;
	logic trig_source_hit;
	logic clear_hit;
	logic save_ok;
	logic recall_ok;
	logic slot_refused;
	logic event_clear;
	logic query_hit;

	function automatic logic masked_any(input logic [7:0] flags, input logic [7:0] mask);
		masked_any = |(flags & mask);
	endfunction

	function automatic logic is_cmd(input logic valid, input cmd_code_t code,
			input cmd_code_t want);
		is_cmd = valid && (code == want);
	endfunction

	// eight-bit registers answer in the low byte, high byte zero
	function automatic logic [15:0] byte_answer(input logic [7:0] value);
		byte_answer = {8'h00, value};
	endfunction

	// command decode
	always_comb begin
		save_hit = is_cmd(i_cmd_valid, i_cmd_code, CMD_SAVE_STATE);
		recall_hit = is_cmd(i_cmd_valid, i_cmd_code, CMD_RECALL_STATE);
		trigger_hit = is_cmd(i_cmd_valid, i_cmd_code, CMD_TRIGGER);
		scpi_hit = is_cmd(i_cmd_valid, i_cmd_code, CMD_SYNTAX_SCPI);
		native_hit = is_cmd(i_cmd_valid, i_cmd_code, CMD_SYNTAX_NATIVE);
		srq_mask_set_hit = is_cmd(i_cmd_valid, i_cmd_code, CMD_SRQ_MASK_SET);
		srq_mask_query_hit = is_cmd(i_cmd_valid, i_cmd_code, CMD_SRQ_MASK_QUERY);
		status_query_hit = is_cmd(i_cmd_valid, i_cmd_code, CMD_STATUS_QUERY);
		event_mask_set_hit = is_cmd(i_cmd_valid, i_cmd_code, CMD_EVENT_MASK_SET);
		event_mask_query_hit = is_cmd(i_cmd_valid, i_cmd_code, CMD_EVENT_MASK_QUERY);
		event_query_hit = is_cmd(i_cmd_valid, i_cmd_code, CMD_EVENT_QUERY);
		questionable_condition_flags_query_hit = is_cmd(i_cmd_valid, i_cmd_code, CMD_QUESTIONABLE_CONDITION_FLAGS_QUERY);
		trig_source_hit = is_cmd(i_cmd_valid, i_cmd_code, CMD_TRIG_SOURCE_SET);
		clear_hit = is_cmd(i_cmd_valid, i_cmd_code, CMD_CLEAR_STATUS);
	end

	// slot number check; an out-of-range slot is refused
	assign slot_ok = (i_cmd_arg <= LAST_SLOT);
	assign slot_idx = i_cmd_arg[3:0];
	assign save_ok = save_hit && slot_ok;
	assign recall_ok = recall_hit && slot_ok;
	assign slot_refused = (save_hit || recall_hit) && !slot_ok;
	assign event_clear = event_query_hit || clear_hit;
	assign query_hit = srq_mask_query_hit || status_query_hit || event_mask_query_hit
		|| event_query_hit || questionable_condition_flags_query_hit;

	// state slots
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			for (int i = 0; i < SLOT_COUNT; i++) begin
				slot_q[i] <= SLOT_RESET;
			end
		end else if (save_ok) begin
			slot_q[slot_idx] <= i_current_state; // R1
		end
	end

	// recall strobe
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			o_recall_valid <= 1'b0;
		end else begin
			o_recall_valid <= recall_ok; // R1
		end
	end

	// recalled state holds until the next legal recall
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			o_recall_state <= SLOT_RESET;
		end else if (recall_ok) begin
			o_recall_state <= slot_q[slot_idx]; // R1
		end
	end

	// trigger source: argument bit 0 high selects the bus
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			trig_bus_q <= 1'b0;
		end else if (trig_source_hit) begin
			trig_bus_q <= i_cmd_arg[0];
		end
	end

	// trigger pulse only while the bus is the source
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			o_trigger_start <= 1'b0;
		end else begin
			o_trigger_start <= trigger_hit && trig_bus_q; // R2
		end
	end

	// command syntax selection
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			o_syntax_scpi <= 1'b1;
		end else if (scpi_hit) begin
			o_syntax_scpi <= 1'b1; // R3
		end else if (native_hit) begin
			o_syntax_scpi <= 1'b0; // R3
		end
	end

	// service request mask
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			srq_mask_q <= SRQ_MASK_RESET;
		end else if (srq_mask_set_hit) begin
			srq_mask_q <= i_cmd_arg; // R6
		end
	end

	// standard event mask
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			event_mask_q <= EVENT_MASK_RESET;
		end else if (event_mask_set_hit) begin
			event_mask_q <= i_cmd_arg; // R13
		end
	end

	// standard event flags: set wins over clear
	always_comb begin
		event_flags_d = event_flags_q;
		if (event_clear) begin
			event_flags_d = 8'h00; // R23
		end
		if (i_ops_done) begin
			event_flags_d[EVT_OP_DONE] = 1'b1; // R14
		end
		if (i_query_error) begin
			event_flags_d[EVT_QUERY_ERR] = 1'b1; // R15
		end
		if (i_exec_error) begin
			event_flags_d[EVT_EXEC_ERR] = 1'b1; // R16
		end
		if (slot_refused) begin
			event_flags_d[EVT_EXEC_ERR] = 1'b1; // R16
		end
		if (i_command_error) begin
			event_flags_d[EVT_CMD_ERR] = 1'b1; // R17
		end
		if (i_power_cycled) begin
			event_flags_d[EVT_POWER_ON] = 1'b1; // R18
		end
		event_flags_d = event_flags_d & EVT_USED; // R19
	end

	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			event_flags_q <= EVENT_FLAGS_RESET; // R18
		end else begin
			event_flags_q <= event_flags_d;
		end
	end

	// output level loop condition
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			unleveled_q <= 1'b0;
		end else begin
			unleveled_q <= i_output_level_loop_unleveled; // R20
		end
	end

	// synthesizer lock condition
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			unlocked_q <= 1'b0;
		end else begin
			unlocked_q <= i_synth_unlocked; // R21
		end
	end

	// external reference condition
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			no_ref_q <= 1'b0;
		end else begin
			no_ref_q <= i_ext_ref_lost; // R22
		end
	end

	// questionable word: only bits 10 to 12 are in use
	always_comb begin
		questionable_condition_flags_word = 16'h0000; // R22
		questionable_condition_flags_word[QUESTIONABLE_CONDITION_FLAGS_UNLEVELED] = unleveled_q; // R20
		questionable_condition_flags_word[QUESTIONABLE_CONDITION_FLAGS_UNLOCKED] = unlocked_q; // R21
		questionable_condition_flags_word[QUESTIONABLE_CONDITION_FLAGS_NO_REF] = no_ref_q; // R22
	end

	// sticky local-control bit
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			local_q <= 1'b0;
		end else if (i_local_press && i_remote_mode) begin
			local_q <= 1'b1; // R7
		end else if (clear_hit) begin
			local_q <= 1'b0;
		end
	end

	// sticky error bit
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			error_q <= 1'b0;
		end else if (i_lang_error) begin
			error_q <= 1'b1; // R9
		end else if (clear_hit) begin
			error_q <= 1'b0;
		end
	end

	// status byte assembly
	always_comb begin
		status_d = 8'h00; // R8
		status_d[STB_LOCAL] = local_q; // R7
		status_d[STB_ERROR] = error_q; // R9
		status_d[STB_QUESTIONABLE_CONDITION_FLAGS] = |questionable_condition_flags_word; // R10
		status_d[STB_MSG] = i_message_waiting; // R11
		status_d[STB_EVENT] = masked_any(event_flags_q, event_mask_q); // R12
		status_d[STB_SRQ] = masked_any(status_d & 8'h3F, srq_mask_q); // R4
	end

	// status byte register
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			status_q <= 8'h00;
		end else begin
			status_q <= status_d;
		end
	end

	// service request level
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			o_service_request <= 1'b0;
		end else begin
			o_service_request <= status_d[STB_SRQ]; // R4
		end
	end

	// answer strobe, one cycle per query
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			o_resp_valid <= 1'b0;
		end else begin
			o_resp_valid <= query_hit; // R5
		end
	end

	// answer word holds until the next query
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			o_resp_data <= 16'h0000;
		end else if (i_cmd_valid) begin
			case (i_cmd_code)
				CMD_STATUS_QUERY: begin
					o_resp_data <= byte_answer(status_q); // R5
				end
				CMD_SRQ_MASK_QUERY: begin
					o_resp_data <= byte_answer(srq_mask_q); // R6
				end
				CMD_EVENT_MASK_QUERY: begin
					o_resp_data <= byte_answer(event_mask_q); // R13
				end
				CMD_EVENT_QUERY: begin
					o_resp_data <= byte_answer(event_flags_q); // R13
				end
				CMD_QUESTIONABLE_CONDITION_FLAGS_QUERY: begin
					o_resp_data <= questionable_condition_flags_word; // R22
				end
				default: begin
					o_resp_data <= o_resp_data;
				end
			endcase
		end
	end

endmodule // instrument_status_reporting

// [logic/status_reporting_pkg.sv]
package status_reporting_pkg;

	// command codes arriving from the command decoder
	typedef enum logic [3:0] {
		CMD_SAVE_STATE = 4'h0,
		CMD_RECALL_STATE = 4'h1,
		CMD_TRIGGER = 4'h2,
		CMD_SYNTAX_SCPI = 4'h3,
		CMD_SYNTAX_NATIVE = 4'h4,
		CMD_SRQ_MASK_SET = 4'h5,
		CMD_SRQ_MASK_QUERY = 4'h6,
		CMD_STATUS_QUERY = 4'h7,
		CMD_EVENT_MASK_SET = 4'h8,
		CMD_EVENT_MASK_QUERY = 4'h9,
		CMD_EVENT_QUERY = 4'hA,
		CMD_QUESTIONABLE_CONDITION_FLAGS_QUERY = 4'hB,
		CMD_TRIG_SOURCE_SET = 4'hC,
		CMD_CLEAR_STATUS = 4'hD
	} cmd_code_t;

	localparam int STATE_W = 32;
	localparam int SLOT_COUNT = 10;
	localparam logic [7:0] LAST_SLOT = 8'h09;

	// status byte bit positions
	localparam int STB_LOCAL = 0;
	localparam int STB_ERROR = 2;
	localparam int STB_QUESTIONABLE_CONDITION_FLAGS = 3;
	localparam int STB_MSG = 4;
	localparam int STB_EVENT = 5;
	localparam int STB_SRQ = 6;

	// standard event bit positions
	localparam int EVT_OP_DONE = 0;
	localparam int EVT_QUERY_ERR = 2;
	localparam int EVT_EXEC_ERR = 4;
	localparam int EVT_CMD_ERR = 5;
	localparam int EVT_POWER_ON = 7;
	localparam logic [7:0] EVT_USED = 8'hB5;

	// questionable bit positions
	localparam int QUESTIONABLE_CONDITION_FLAGS_UNLEVELED = 10;
	localparam int QUESTIONABLE_CONDITION_FLAGS_UNLOCKED = 11;
	localparam int QUESTIONABLE_CONDITION_FLAGS_NO_REF = 12;

	// reset values
	localparam logic [7:0] SRQ_MASK_RESET = 8'h00;
	localparam logic [7:0] EVENT_MASK_RESET = 8'h00;
	localparam logic [7:0] EVENT_FLAGS_RESET = 8'h80;
	localparam logic [STATE_W-1:0] SLOT_RESET = 32'h0000_0000;

endpackage

// [testbench/status_host.sv]
`timescale 1ns/10ps
module status_host import status_reporting_pkg::*; (
	// clock
	input wire logic i_clock,
	// command lines
	output logic o_cmd_valid,
	output cmd_code_t o_cmd_code,
	output logic [7:0] o_cmd_arg
);
	initial begin
		o_cmd_valid = 1'b0;
		o_cmd_code = CMD_CLEAR_STATUS;
		o_cmd_arg = 8'h00;
	end
	// one-cycle strobe; argument scrambled once released
	task automatic send(input cmd_code_t c, input logic [7:0] a);
		@(negedge i_clock);
		o_cmd_valid = 1'b1;
		o_cmd_code = c;
		o_cmd_arg = a;
		@(negedge i_clock);
		o_cmd_valid = 1'b0;
		o_cmd_arg = ~a;
	endtask
endmodule // status_host

// [testbench/status_reporting_checker.sv]
`timescale 1ns/10ps
module status_reporting_checker import status_reporting_pkg::*; (
	// watched ports
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic i_cmd_valid,
	input wire cmd_code_t i_cmd_code,
	input wire logic [7:0] i_cmd_arg,
	input wire logic o_resp_valid,
	input wire logic [15:0] o_resp_data,
	input wire logic o_recall_valid,
	input wire logic o_trigger_start,
	input wire logic o_syntax_scpi
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rstn);
	wire q = i_cmd_valid && (i_cmd_code inside {4'h6, 4'h7, 4'h9, 4'hA, 4'hB});
	property p_ans; q |=> o_resp_valid; endproperty
	a_ans: assert property (p_ans) else $error("query not answered");
	property p_quiet; !q |=> !o_resp_valid; endproperty
	a_quiet: assert property (p_quiet) else $error("answer without query");
	property p_stb; o_resp_valid && $past(i_cmd_code) == CMD_STATUS_QUERY
		|-> o_resp_data[15:7] == 9'h000 && !o_resp_data[1]; endproperty
	a_stb: assert property (p_stb) else $error("unused status bit set");
	property p_evt; o_resp_valid && $past(i_cmd_code) == CMD_EVENT_QUERY
		|-> (o_resp_data & 16'hFF4A) == 16'h0000; endproperty
	a_evt: assert property (p_evt) else $error("unused event bit set");
	property p_questionable_condition_flags; o_resp_valid && $past(i_cmd_code) == CMD_QUESTIONABLE_CONDITION_FLAGS_QUERY
		|-> (o_resp_data & 16'hE3FF) == 16'h0000; endproperty
	a_questionable_condition_flags: assert property (p_questionable_condition_flags) else $error("unused condition bit set");
	property p_trg; o_trigger_start |-> $past(i_cmd_valid && i_cmd_code == CMD_TRIGGER); endproperty
	a_trg: assert property (p_trg) else $error("trigger without command");
	property p_rcl; o_recall_valid |-> $past(i_cmd_valid && i_cmd_code == CMD_RECALL_STATE
		&& i_cmd_arg <= LAST_SLOT); endproperty
	a_rcl: assert property (p_rcl) else $error("bad recall pulse");
	property p_scpi; i_cmd_valid && i_cmd_code == CMD_SYNTAX_SCPI |=> o_syntax_scpi; endproperty
	a_scpi: assert property (p_scpi) else $error("scpi not selected");
	property p_nat; i_cmd_valid && i_cmd_code == CMD_SYNTAX_NATIVE |=> !o_syntax_scpi; endproperty
	a_nat: assert property (p_nat) else $error("native not selected");
endmodule // status_reporting_checker
bind instrument_status_reporting status_reporting_checker status_reporting_checker_inst (
	.i_clock, .i_rstn, .i_cmd_valid, .i_cmd_code, .i_cmd_arg, .o_resp_valid,
	.o_resp_data, .o_recall_valid, .o_trigger_start, .o_syntax_scpi);

// [testbench/tb_instrument_status_reporting.sv]
`timescale 1ns/10ps
module tb_instrument_status_reporting;
	import status_reporting_pkg::*;
	logic i_clock = 1'b0;
	logic i_rstn = 1'b0;
	logic [11:0] src = 12'h000;
	logic [31:0] st = 32'h0000_0000;
	logic cv, rv, cl, tr, sy, sr;
	cmd_code_t cc;
	logic [7:0] ca;
	logic [15:0] rd;
	logic [31:0] rs;
	int mismatches = 0;
	int samples_checked = 0;
	always #20 i_clock = ~i_clock;
	status_host status_host_inst (.i_clock(i_clock), .o_cmd_valid(cv), .o_cmd_code(cc),
		.o_cmd_arg(ca));
	instrument_status_reporting instrument_status_reporting_inst (.i_clock(i_clock),
		.i_rstn(i_rstn), .i_cmd_valid(cv), .i_cmd_code(cc), .i_cmd_arg(ca),
		.i_current_state(st), .i_remote_mode(src[0]), .i_local_press(src[1]),
		.i_lang_error(src[2]), .i_message_waiting(src[3]), .i_ops_done(src[4]),
		.i_query_error(src[5]), .i_exec_error(src[6]), .i_command_error(src[7]),
		.i_power_cycled(src[8]), .i_output_level_loop_unleveled(src[9]),
		.i_synth_unlocked(src[10]), .i_ext_ref_lost(src[11]), .o_resp_valid(rv),
		.o_resp_data(rd), .o_recall_valid(cl), .o_recall_state(rs),
		.o_trigger_start(tr), .o_syntax_scpi(sy), .o_service_request(sr));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cmd(input cmd_code_t c, input logic [7:0] a);
		status_host_inst.send(c, a);
	endtask
	task automatic query(input cmd_code_t c, input logic [15:0] exp);
		cmd(c, 8'h00);
		check(rv, 1'b1);
		check(rd, exp);
	endtask
	task automatic close_out;
		$display("checks %0d, mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		#2000000;
		mismatches++;
		close_out;
	end
	initial begin
		repeat (16) @(negedge i_clock);
		i_rstn = 1'b1;
		check(sy, 1'b1);
		query(CMD_STATUS_QUERY, 16'h0000);
		query(CMD_EVENT_QUERY, 16'h0080);
		query(CMD_EVENT_QUERY, 16'h0000);
		$display("test reset done");
		cmd(CMD_SRQ_MASK_SET, 8'hFF);
		query(CMD_SRQ_MASK_QUERY, 16'h00FF);
		cmd(CMD_EVENT_MASK_SET, 8'hFF);
		query(CMD_EVENT_MASK_QUERY, 16'h00FF);
		$display("test masks done");
		@(negedge i_clock);
		src = 12'h1F0;
		@(negedge i_clock);
		src = 12'h000;
		repeat (2) @(negedge i_clock);
		check(sr, 1'b1);
		query(CMD_STATUS_QUERY, 16'h0060);
		query(CMD_EVENT_QUERY, 16'h00B5);
		$display("test events done");
		src = 12'hE0F;
		repeat (2) @(negedge i_clock);
		query(CMD_QUESTIONABLE_CONDITION_FLAGS_QUERY, 16'h1C00);
		query(CMD_STATUS_QUERY, 16'h005D);
		cmd(CMD_SRQ_MASK_SET, 8'h20);
		query(CMD_STATUS_QUERY, 16'h001D);
		check(sr, 1'b0);
		src = 12'h000;
		cmd(CMD_CLEAR_STATUS, 8'h00);
		repeat (2) @(negedge i_clock);
		query(CMD_STATUS_QUERY, 16'h0000);
		$display("test conditions done");
		st = 32'hA5A5_0009;
		cmd(CMD_SAVE_STATE, 8'h09);
		st = 32'h1234_0000;
		cmd(CMD_SAVE_STATE, 8'h00);
		cmd(CMD_SAVE_STATE, 8'h0A);
		cmd(CMD_RECALL_STATE, 8'h09);
		check(cl, 1'b1);
		check(rs, 32'hA5A5_0009);
		cmd(CMD_RECALL_STATE, 8'h00);
		check(rs, 32'h1234_0000);
		cmd(CMD_RECALL_STATE, 8'h0A);
		check(cl, 1'b0);
		cmd(CMD_EVENT_MASK_SET, 8'h01);
		query(CMD_STATUS_QUERY, 16'h0000);
		query(CMD_EVENT_QUERY, 16'h0010);
		$display("test slots done");
		cmd(CMD_TRIGGER, 8'h00);
		check(tr, 1'b0);
		cmd(CMD_TRIG_SOURCE_SET, 8'h01);
		cmd(CMD_TRIGGER, 8'h00);
		check(tr, 1'b1);
		cmd(CMD_SYNTAX_NATIVE, 8'h00);
		check(sy, 1'b0);
		cmd(CMD_SYNTAX_SCPI, 8'h00);
		check(sy, 1'b1);
		$display("test trigger and syntax done");
		close_out;
	end
endmodule // tb_instrument_status_reporting
